/* hw/laser_safety_pkg.sv */
// Package: shared constants and carriers for the laser safety fault logic
package laser_safety_pkg;

  // Number of fault conditions, one safety cell each
  localparam int unsigned NUM_COND = 8;

  // Cell positions within a condition vector
  localparam int unsigned COND_BIAS  = 0;
  localparam int unsigned COND_APC   = 1;
  localparam int unsigned COND_VREF  = 2;
  localparam int unsigned COND_VDD   = 3;
  localparam int unsigned COND_TXDIS = 4;
  localparam int unsigned COND_SOFT  = 5;
  localparam int unsigned COND_ROGUE = 6;
  localparam int unsigned COND_ALARM = 7;

  // Diagnostic alarm flag count
  localparam int unsigned NUM_ALARM = 8;

  // Bias short settle time after shutdown release
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned BIAS_SETTLE_US = 250;
  localparam int unsigned BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int unsigned SETTLE_W      = 17;

  // Pin placement selector values
  localparam logic PLACE_LOW  = 1'b0;
  localparam logic PLACE_HIGH = 1'b1;

  // Reset values
  localparam logic [NUM_COND-1:0] COND_RST   = 8'h00;
  localparam logic [1:0]          SYNC_RST   = 2'h0;

  // One configuration set for a safety chain
  typedef struct packed {
    logic [NUM_COND-1:0] pass_en;
    logic [NUM_COND-1:0] sticky_en;
  } chain_cfg_t;

  // Raw asynchronous inputs, synchronised as one bundle
  typedef struct packed {
    logic bias_short;
    logic mpd_short;
    logic reference_resistor_pin_short;
    logic tx_brownout;
    logic txo_brownout;
    logic disable_pin;
    logic rogue_emit;
    logic supply_low;
  } raw_in_t;

endpackage

/* hw/laser_safety_fault_logic.sv */
// Laser safety fault logic: condition gathering, two safety chains, inhibit
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Produce separate fault status and shutdown control
// - Fault status readable and routed to chosen pin
// - Shutdown disables bias and modulation currents
// - Bias, monitor, reference pin shorts raise faults
// - Brownout on either transmit rail raises fault
// - Disable fault: pin XOR invert, OR software
// - Emission between bursts raises rogue fault
// - Masked diagnostic alarm flags raise alarm fault
// - Bias short ignored while in shutdown
// - Bias short ignored 250us after shutdown release
// - Cell passes condition only when enabled
// - Latch enable selects sticky copy of condition
// - Latch reset when disabled or disable fault
// - Inhibit resets latches, forces fault status high
// - Inhibit asserted at power-on reset
// - Pin configuration load clears inhibit
// - Raw condition register shows live cell inputs
// - Shutdown path duplicates cells with own enables
// - Shutdown state readable in hardware status
// - Transmit supply below 2.7V asserts shutdown
module laser_safety_fault_logic
  import laser_safety_pkg::*;
(
  input  wire logic                 sys_clk,                 // System clock, 250 MHz
  input  wire logic                 rst,                     // Async reset, active high
  input  wire raw_in_t              raw_in,                  // Asynchronous detector and pin levels
  input  wire logic                 disable_invert,          // Invert sense of disable pin
  input  wire logic                 soft_disable,            // Software transmit disable
  input  wire logic                 soft_fault,              // Software fault bit
  input  wire logic [NUM_ALARM-1:0] alarm_flags,             // Diagnostic alarm flags
  input  wire logic [NUM_ALARM-1:0] alarm_contribution_mask, // Which alarms count
  input  wire chain_cfg_t           fault_cfg,               // Status chain enables
  input  wire chain_cfg_t           off_cfg,                 // Shutdown chain enables
  input  wire logic                 pin_placement_cfg,       // Fault pin position select
  input  wire logic                 pin_cfg_load,            // Pin configuration loaded pulse
  output logic                      fault_status,            // Fault status, also software readable
  output logic                      fault_pin_low,           // Fault indication, first position
  output logic                      fault_pin_high,          // Fault indication, second position
  output logic                      laser_off,               // Shutdown control
  output logic                      bias_current_en,         // Bias current enable
  output logic                      mod_current_en,          // Modulation current enable
  output logic                      shutdown_state,          // Hardware status shutdown bit
  output logic                      inhibit_state,           // Laser inhibit level
  output logic [NUM_COND-1:0]       raw_condition_reg        // Live conditions at cell inputs
);

  // Whole module state
  typedef struct packed {
    raw_in_t             sync1;     // First synchroniser stage
    raw_in_t             sync2;     // Second synchroniser stage
    logic [NUM_COND-1:0] cond;      // Registered cell inputs
    logic [NUM_COND-1:0] f_latch;   // Status chain sticky copies
    logic [NUM_COND-1:0] s_latch;   // Shutdown chain sticky copies
    logic                fault;     // Status chain output
    logic                off;       // Shutdown chain output
    logic                inhibit;   // Laser inhibit
    logic [SETTLE_W-1:0] settle;    // Bias short settle countdown
  } state_t;

  state_t s_q;  // Registered state
  state_t s_d;  // Next state

  // One safety chain: returns next latch contents
  function automatic logic [NUM_COND-1:0] next_latch(
    input logic [NUM_COND-1:0] cond,
    input logic [NUM_COND-1:0] latch,
    input logic [NUM_COND-1:0] sticky_en,
    input logic                clr_all
  );
    logic [NUM_COND-1:0] res;
    res = (latch | cond) & sticky_en;  // Held while enabled
    if (clr_all)
    begin
      res = COND_RST;  // Inhibit or disable fault clears all
    end
    return res;
  endfunction

  // Chain output: enabled live or sticky conditions, ORed
  function automatic logic chain_out(
    input logic [NUM_COND-1:0] cond,
    input logic [NUM_COND-1:0] latch,
    input chain_cfg_t          cfg
  );
    logic [NUM_COND-1:0] sel;
    sel = (cfg.sticky_en & latch) | (~cfg.sticky_en & cond);
    return |(sel & cfg.pass_en);
  endfunction

  // Next state logic
  always_comb
  begin
    logic                bias_ok;
    logic                clr;
    logic [NUM_COND-1:0] c;
    bias_ok = 1'b0;
    clr     = 1'b0;
    c       = COND_RST;
    s_d = s_q;
    // Two-stage synchroniser; first stage read only by second
    s_d.sync1 = raw_in;
    s_d.sync2 = s_q.sync1;
    // Settle countdown restarts while shut down
    if (s_q.off)
    begin
      s_d.settle = SETTLE_W'(BIAS_SETTLE_CYC);
    end
    else if (s_q.settle != '0)
    begin
      s_d.settle = s_q.settle - 1'b1;
    end
    // Bias short used only when running and settled
    bias_ok = !s_q.off && (s_q.settle == '0);
    // Gather conditions
    c[COND_BIAS]  = s_q.sync2.bias_short && bias_ok;
    c[COND_APC]   = s_q.sync2.mpd_short;
    c[COND_VREF]  = s_q.sync2.reference_resistor_pin_short;
    c[COND_VDD]   = s_q.sync2.tx_brownout | s_q.sync2.txo_brownout;
    c[COND_TXDIS] = (s_q.sync2.disable_pin ^ disable_invert) | soft_disable;
    c[COND_SOFT]  = soft_fault;
    c[COND_ROGUE] = s_q.sync2.rogue_emit;
    c[COND_ALARM] = |(alarm_flags & alarm_contribution_mask);
    s_d.cond = c;
    // Latch reset causes
    clr = s_q.inhibit || s_q.cond[COND_TXDIS];
    s_d.f_latch = next_latch(s_q.cond, s_q.f_latch, fault_cfg.sticky_en, clr);
    s_d.s_latch = next_latch(s_q.cond, s_q.s_latch, off_cfg.sticky_en, clr);
    // Status chain output, forced high under inhibit
    s_d.fault = s_q.inhibit || chain_out(s_q.cond, s_q.f_latch, fault_cfg);
    // Shutdown chain plus supply detector, which bypasses enables
    s_d.off = chain_out(s_q.cond, s_q.s_latch, off_cfg) || s_q.sync2.supply_low;
    // Inhibit released by pin configuration load
    if (pin_cfg_load)
    begin
      s_d.inhibit = 1'b0;
    end
  end

  // State register; inhibit set at power-on
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q         <= '0;
      s_q.inhibit <= 1'b1;
      s_q.fault   <= 1'b1;
      s_q.off     <= 1'b1;
      s_q.settle  <= SETTLE_W'(BIAS_SETTLE_CYC);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs; fault pin routed by placement select
  always_comb
  begin
    fault_status      = s_q.fault;
    fault_pin_low     = (pin_placement_cfg == PLACE_LOW)  && s_q.fault;
    fault_pin_high    = (pin_placement_cfg == PLACE_HIGH) && s_q.fault;
    laser_off         = s_q.off;
    bias_current_en   = !s_q.off;
    mod_current_en    = !s_q.off;
    shutdown_state    = s_q.off;
    inhibit_state     = s_q.inhibit;
    raw_condition_reg = s_q.cond;
  end

  // Assertions
  // All properties share the system clock and drop out while reset is high

  // Shutdown falling: one cycle off, the next cycle running
  sequence off_release;
    s_q.off ##1 !s_q.off;
  endsequence

  // Soft cell enabled live: passes without a sticky copy
  sequence soft_live_pass;
    !s_q.inhibit && fault_cfg.pass_en[COND_SOFT] && !fault_cfg.sticky_en[COND_SOFT] && s_q.cond[COND_SOFT];
  endsequence

  // Soft cell enabled sticky with its copy set
  sequence soft_sticky_pass;
    !s_q.inhibit && fault_cfg.pass_en[COND_SOFT] && fault_cfg.sticky_en[COND_SOFT] && s_q.f_latch[COND_SOFT];
  endsequence

  // Rogue cell free to latch: enabled, no reset cause present
  sequence rogue_latch_armed;
    s_q.cond[COND_ROGUE] && fault_cfg.sticky_en[COND_ROGUE] && !s_q.inhibit && !s_q.cond[COND_TXDIS];
  endsequence

  // Inhibit keeps the host seeing a fault until configuration is in
  a_inhibit_forces_fault: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.inhibit |=> fault_status) else $error("Fault status low under inhibit");

  // No sticky copy may survive a cycle of inhibit
  a_inhibit_clears_latch: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.inhibit |=> (s_q.f_latch == '0 && s_q.s_latch == '0)) else $error("Latch set under inhibit");

  // Load pulse releases inhibit on the next edge
  a_cfg_load_release: assert property (@(posedge sys_clk) disable iff (rst)
    pin_cfg_load |=> !inhibit_state) else $error("Inhibit not cleared");

  // Both laser currents follow shutdown with no lag
  a_shutdown_gates_cur: assert property (@(posedge sys_clk) disable iff (rst)
    laser_off |-> (!bias_current_en && !mod_current_en)) else $error("Current on in shutdown");

  // Bias short masked while the laser is held off
  a_bias_ignored_off: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.off |=> !s_q.cond[COND_BIAS]) else $error("Bias short used in shutdown");

  // Detector still settling just after release; a short window is enough here
  a_bias_settle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    off_release |-> (!s_q.off)[*8] |=> !s_q.cond[COND_BIAS]) else $error("Bias short used early");

  // Low supply forces shutdown whatever the enables say
  a_supply_low_off: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.sync2.supply_low |=> laser_off) else $error("No shutdown on low supply");

  // Disable condition is pin XOR invert, OR software bit
  a_disable_fault_eq: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_TXDIS] == (($past(s_q.sync2.disable_pin) ^ $past(disable_invert)) | $past(soft_disable)))
    else $error("Disable fault wrong");

  // Sticky copy holds while no reset cause is present
  a_sticky_holds: assert property (@(posedge sys_clk) disable iff (rst)
    (s_q.f_latch[COND_SOFT] && fault_cfg.sticky_en[COND_SOFT] && !s_q.inhibit && !s_q.cond[COND_TXDIS])
    |=> s_q.f_latch[COND_SOFT]) else $error("Sticky cell dropped");

  // Exactly one pin position carries the fault, never both
  a_pin_route: assert property (@(posedge sys_clk) disable iff (rst)
    !(fault_pin_low && fault_pin_high) && ((fault_pin_low || fault_pin_high) == fault_status))
    else $error("Fault pin routing wrong");

  // Second stage only ever copies the first
  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.sync2 == $past(s_q.sync1)) else $error("Synchroniser stage skipped");

  // Monitor pin short reaches its cell unchanged
  a_apc_short_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_APC] == $past(s_q.sync2.mpd_short)) else $error("Monitor short lost");

  // Reference pin short reaches its cell unchanged
  a_ref_short_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_VREF] == $past(s_q.sync2.reference_resistor_pin_short)) else $error("Reference short lost");

  // Either rail browning out is enough
  a_brownout_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_VDD] == ($past(s_q.sync2.tx_brownout) | $past(s_q.sync2.txo_brownout)))
    else $error("Brownout condition wrong");

  // Software fault bit drives its cell directly
  a_soft_fault_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_SOFT] == $past(soft_fault)) else $error("Software fault lost");

  // Emission between bursts reaches its cell
  a_rogue_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_ROGUE] == $past(s_q.sync2.rogue_emit)) else $error("Rogue emission lost");

  // Only unmasked alarm flags count
  a_alarm_mask_cond: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 s_q.cond[COND_ALARM] == |($past(alarm_flags) & $past(alarm_contribution_mask)))
    else $error("Alarm condition wrong");

  // Nothing passes a chain whose cells are all disabled
  a_no_pass_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    (!s_q.inhibit && fault_cfg.pass_en == '0) |=> !fault_status) else $error("Disabled cell passed");

  // Shutdown chain honours its own enables; only low supply bypasses them
  a_off_no_pass: assert property (@(posedge sys_clk) disable iff (rst)
    (off_cfg.pass_en == '0 && !s_q.sync2.supply_low) |=> !laser_off)
    else $error("Shutdown without enabled cell");

  // Live cell passes its condition on the next edge
  a_live_cell_pass: assert property (@(posedge sys_clk) disable iff (rst)
    soft_live_pass |=> fault_status) else $error("Live cell not passed");

  // Sticky cell passes its copy, not the live level
  a_sticky_cell_pass: assert property (@(posedge sys_clk) disable iff (rst)
    soft_sticky_pass |=> fault_status) else $error("Sticky cell not passed");

  // Disable fault empties both chains' copies
  a_txdis_clears_latch: assert property (@(posedge sys_clk) disable iff (rst)
    s_q.cond[COND_TXDIS] |=> (s_q.f_latch == '0 && s_q.s_latch == '0)) else $error("Latch kept on disable");

  // Latching switched off keeps copies in reset
  a_unstick_clears: assert property (@(posedge sys_clk) disable iff (rst)
    (fault_cfg.sticky_en == '0 && off_cfg.sticky_en == '0) |=> (s_q.f_latch == '0 && s_q.s_latch == '0))
    else $error("Latch kept while disabled");

  // Armed cell catches its condition on the next edge
  a_latch_sets: assert property (@(posedge sys_clk) disable iff (rst)
    rogue_latch_armed |=> s_q.f_latch[COND_ROGUE]) else $error("Sticky cell not set");

  // Status bit mirrors the shutdown control
  a_shutdown_status: assert property (@(posedge sys_clk) disable iff (rst)
    shutdown_state == laser_off) else $error("Shutdown status wrong");

  // Once released, only reset can bring inhibit back
  a_inhibit_no_return: assert property (@(posedge sys_clk) disable iff (rst)
    !s_q.inhibit |=> !s_q.inhibit) else $error("Inhibit returned");

endmodule

`default_nettype wire

/* bench/host_fault_monitor.sv */
// Host model: loads the pin configuration once, reads the fault pin
`timescale 1ns/1ps
`default_nettype none
module host_fault_monitor #(
  parameter int LOAD_DLY = 30 // Cycles from reset release to load
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin_placement_cfg,
  input  wire logic fault_pin_low,
  input  wire logic fault_pin_high,
  output logic      pin_cfg_load,
  output logic      host_fault_seen
);
  int cnt_q; // Cycles since reset release
  // One load pulse per reset; inhibit cannot return without reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 0;
      pin_cfg_load <= 1'b0;
    end
    else
    begin
      if (cnt_q <= LOAD_DLY) cnt_q <= cnt_q + 1;
      pin_cfg_load <= (cnt_q == LOAD_DLY);
    end
  end
  // Host follows whichever position is selected
  assign host_fault_seen = pin_placement_cfg ? fault_pin_high : fault_pin_low;
endmodule
`default_nettype wire

/* bench/laser_safety_fault_logic_tb_top.sv */
// Bench with a reference model of both safety chains
`timescale 1ns/1ps
`default_nettype none
module laser_safety_fault_logic_tb_top;
  import laser_safety_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  raw_in_t    raw = '0;
  logic       inv = 1'b0, sdis = 1'b0, sfault = 1'b0, place = 1'b0;
  logic [7:0] flags = '0, mask = '0;
  chain_cfg_t fcfg = '0, ocfg = '0;
  logic       load, seen, fst, fpl, fph, loff, ben, men, sst, ist;
  logic [7:0] rcr;
  logic [7:0] lat_f = '0, lat_o = '0; // Model latches
  logic       inh = 1'b1, bias_ok = 1'b0; // Model inhibit, bias usable
  int         err_total = 0, num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  laser_safety_fault_logic dut_u (.sys_clk(sys_clk), .rst(rst), .raw_in(raw), .disable_invert(inv),
    .soft_disable(sdis), .soft_fault(sfault), .alarm_flags(flags), .alarm_contribution_mask(mask),
    .fault_cfg(fcfg), .off_cfg(ocfg), .pin_placement_cfg(place), .pin_cfg_load(load),
    .fault_status(fst), .fault_pin_low(fpl), .fault_pin_high(fph), .laser_off(loff),
    .bias_current_en(ben), .mod_current_en(men), .shutdown_state(sst), .inhibit_state(ist),
    .raw_condition_reg(rcr));
  host_fault_monitor #(.LOAD_DLY(30)) host_u (.sys_clk(sys_clk), .rst(rst), .pin_placement_cfg(place),
    .fault_pin_low(fpl), .fault_pin_high(fph), .pin_cfg_load(load), .host_fault_seen(seen));
  // Inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] cond();
    return {|(flags & mask), raw.rogue_emit, sfault, (raw.disable_pin ^ inv) | sdis,
            raw.tx_brownout | raw.txo_brownout, raw.reference_resistor_pin_short, raw.mpd_short, raw.bias_short & bias_ok};
  endfunction
  function automatic logic chain(input chain_cfg_t g, input logic [7:0] l, input logic [7:0] c);
    return |(g.pass_en & ((g.sticky_en & l) | (~g.sticky_en & c)));
  endfunction
  // Settled state only; callers hold inputs 8 cycles first
  task automatic chk();
    logic [7:0] c;
    logic       ef, eo;
    c = cond();
    lat_f = (c[4] | inh) ? 8'h00 : (lat_f | c) & fcfg.sticky_en;
    lat_o = (c[4] | inh) ? 8'h00 : (lat_o | c) & ocfg.sticky_en;
    ef = inh | chain(fcfg, lat_f, c);
    eo = raw.supply_low | chain(ocfg, lat_o, c);
    cmp(rcr, c, "raw");
    cmp(fst, ef, "fault");
    cmp(seen, ef, "host");
    cmp({fpl, fph}, {ef & !place, ef & place}, "pins");
    cmp(loff, eo, "off");
    cmp({ben, men, sst}, {!eo, !eo, eo}, "currents");
    cmp(ist, inh, "inhibit");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    logic [1:0] ops [4];
    int         k;
    ops = '{2'b10, 2'b00, 2'b01, 2'b00};
    void'($urandom(94486));
    step(10);
    rst = 1'b0;
    step(8);
    chk();
    raw.rogue_emit = 1'b1;
    fcfg = '{8'h40, 8'h40};
    step(8);
    chk();
    raw.rogue_emit = 1'b0;
    for (k = 0; k < 60 && ist !== 1'b0; k++) step(1);
    inh = 1'b0;
    step(8);
    chk();
    $display("test inhibit finished");
    // Sticky set, hold, clear by disable fault
    foreach (ops[i])
    begin
      {raw.rogue_emit, sdis} = ops[i];
      step(8);
      chk();
    end
    $display("test sticky finished");
    repeat (30)
    begin
      raw = raw_in_t'(8'($urandom));
      raw.bias_short = 1'b0;
      // Pins need two more edges through the synchroniser; keep all cells in step
      step(2);
      {sdis, sfault, place} = 3'($urandom);
      {flags, mask} = 16'($urandom);
      step(8);
      chk();
      {fcfg, ocfg} = 32'($urandom);
      step(8);
      chk();
    end
    $display("test random finished");
    {raw, sdis, sfault, flags} = '0;
    fcfg = '{8'h10, 8'h00};
    ocfg = '0;
    for (k = 0; k < 4; k++)
    begin
      {raw.disable_pin, inv} = 2'(k);
      step(8);
      chk();
    end
    $display("test disable finished");
    // Bias short waits out the settle time after shutdown release
    inv = 1'b0;
    fcfg = '{8'h01, 8'h00};
    step(8);
    raw.bias_short = 1'b1;
    step(BIAS_SETTLE_CYC - 100);
    chk();
    bias_ok = 1'b1;
    step(200);
    chk();
    raw.supply_low = 1'b1;
    bias_ok = 1'b0;
    step(8);
    chk();
    $display("test bias finished");
    give_verdict();
  end
  // Watchdog at 80000 cycles, about a quarter beyond the expected run length
  initial
  begin
    #(4 * 80000);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
